/* File: src/sff_pkg.sv */
// Shared constants and types for the serial frame-format controller
package sff_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG   = 8'h00;
	localparam logic [7:0] OFF_DATA     = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

	// Configuration word field positions
	localparam int FLD_SIZE_LSB  = 0;
	localparam int FLD_TXLVL_LSB = 10;
	localparam int FLD_RSVD_A    = 13;
	localparam int FLD_WAIT_LSB  = 14;
	localparam int FLD_ORDER_LSB = 18;
	localparam int FLD_RSVD_B    = 20;
	localparam int FLD_RXDLY     = 21;

	// Status word field positions
	localparam int STS_COUNT_LSB = 0;
	localparam int STS_FULL      = 8;
	localparam int STS_RXVALID   = 9;
	localparam int STS_BUSY      = 10;
	localparam int STS_TXREQ     = 11;

	// Reset values of configuration fields
	localparam logic [2:0] RST_TXLVL   = 3'h0;
	localparam logic [3:0] RST_WAIT    = 4'h0;
	localparam logic [1:0] RST_ORDER   = 2'h0;
	localparam logic       RST_RXDLY   = 1'b0;
	localparam logic [4:0] RST_SIZE_M1 = 5'h07;

	// Transmit FIFO request level codes and their entry counts
	localparam logic [2:0] TXLVL_1   = 3'h0;
	localparam logic [2:0] TXLVL_4   = 3'h1;
	localparam logic [2:0] TXLVL_8   = 3'h2;
	localparam int         LEVEL_ONE = 1;
	localparam int         LEVEL_4   = 4;
	localparam int         LEVEL_8   = 8;

	// Element order codes
	localparam logic [1:0] ORD_MSBY_MSBI = 2'h0;
	localparam logic [1:0] ORD_LSBY_MSBI = 2'h1;
	localparam logic [1:0] ORD_MSBY_LSBI = 2'h2;
	localparam logic [1:0] ORD_LSBY_LSBI = 2'h3;

	// Interrupt status bits
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_RXOVR = 1;
	localparam int IRQ_TXUND = 2;
	localparam int IRQ_TXREQ = 3;
	localparam int IRQ_W     = 4;

	typedef struct packed {
		logic       rxDelay;
		logic [1:0] order;
		logic [3:0] interframeWaitCount;
		logic [2:0] txFifoIrqLevel;
		logic [4:0] sizeM1;
	} sff_cfg_s;

	localparam sff_cfg_s CFG_RESET = '{
		rxDelay:             RST_RXDLY,
		order:               RST_ORDER,
		interframeWaitCount: RST_WAIT,
		txFifoIrqLevel:      RST_TXLVL,
		sizeM1:              RST_SIZE_M1
	};

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_WAIT} sff_state_e;

endpackage

/* File: src/sff_frame_ctrl.sv */
// Serial slave with frame-format configuration, transmit FIFO and interrupts
`timescale 1ns/1ps
`default_nettype none
module sff_frame_ctrl #(
	parameter int TX_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [31:0] regRdata,
	// Serial link
	input  wire logic        spiSclk,
	input  wire logic        spiCsN,
	input  wire logic        spiMosi,
	output var  logic        spiMiso,
	output var  logic        spiMisoOe,
	// Requests and interrupt
	output var  logic        txReq,
	output var  logic        irq
);
	import sff_pkg::*;

	localparam int PW = $clog2(TX_DEPTH);
	localparam int CW = $clog2(TX_DEPTH + 1);

	// Bit position of step k within an element, for both directions
	function automatic logic [4:0] bitIndex(input logic [4:0] k, input logic [5:0] nBits,
		input logic [1:0] order);
		logic [5:0] idx;
		logic [1:0] lastByte;
		lastByte = nBits[4:3] - 2'h1;
		case (order)
			ORD_MSBY_MSBI: idx = nBits - 6'h01 - {1'b0, k};
			ORD_LSBY_MSBI: idx = {1'b0, k[4:3], 3'h7 - k[2:0]};
			ORD_MSBY_LSBI: idx = {1'b0, lastByte - k[4:3], k[2:0]};
			default:       idx = {1'b0, k};
		endcase
		return idx[4:0];
	endfunction

	// Link synchronisers
	logic sclkMeta, sclkSync, sclkPrev;
	logic csnMeta, csnSync;
	logic mosiMeta, mosiSync, mosiDly1, mosiDly2;

	// Register state
	sff_cfg_s             cfg_reg, cfg_next;
	logic [IRQ_W-1:0]     irqStat_reg, irqStat_next;
	logic [IRQ_W-1:0]     irqMask_reg, irqMask_next;
	logic [31:0]          rdata_reg, rdata_next;
	logic                 irq_reg, irq_next;
	logic                 txReq_reg, txReq_next;

	// FIFO state
	logic [31:0]          fifoMem [TX_DEPTH];
	logic [PW-1:0]        wrPtr_reg, wrPtr_next;
	logic [PW-1:0]        rdPtr_reg, rdPtr_next;
	logic [CW-1:0]        count_reg, count_next;
	logic                 push, pop;

	// Link engine state
	sff_state_e           state_reg, state_next;
	logic [31:0]          txWord_reg, txWord_next;
	logic [31:0]          rxShift_reg, rxShift_next;
	logic [31:0]          rxHold_reg, rxHold_next;
	logic                 rxValid_reg, rxValid_next;
	logic [4:0]           bitCnt_reg, bitCnt_next;
	logic [3:0]           waitCnt_reg, waitCnt_next;
	logic                 miso_reg, miso_next;
	logic                 misoOe_reg, misoOe_next;

	logic                 sclkRise, sclkFall, rxBit, selected;
	logic [5:0]           nBits;
	logic [CW-1:0]        level;
	logic [IRQ_W-1:0]     events;
	logic [31:0]          cfgRead, stsRead;
	logic [31:0]          popWord;

	assign sclkRise = sclkSync & ~sclkPrev;
	assign sclkFall = ~sclkSync & sclkPrev;
	assign selected = ~csnSync;
	assign nBits    = {1'b0, cfg_reg.sizeM1} + 6'h01;
	assign rxBit    = cfg_reg.rxDelay ? mosiDly2 : mosiSync;
	assign popWord  = fifoMem[rdPtr_reg];

	always_ff @(posedge core_clk) begin
		sclkMeta <= spiSclk;
		sclkSync <= sclkMeta;
		sclkPrev <= sclkSync;
		csnMeta  <= spiCsN;
		csnSync  <= csnMeta;
		mosiMeta <= spiMosi;
		mosiSync <= mosiMeta;
		mosiDly1 <= mosiSync;
		mosiDly2 <= mosiDly1;
	end

	// Level threshold; reserved codes fall back to one entry
	always_comb begin
		case (cfg_reg.txFifoIrqLevel)
			TXLVL_1: level = CW'(LEVEL_ONE);
			TXLVL_4: level = CW'(LEVEL_4);
			TXLVL_8: level = CW'(LEVEL_8);
			default: level = CW'(LEVEL_ONE);
		endcase
	end

	// Read views
	always_comb begin
		cfgRead = 32'h0000_0000;
		cfgRead[FLD_SIZE_LSB  +: 5] = cfg_reg.sizeM1;
		cfgRead[FLD_TXLVL_LSB +: 3] = cfg_reg.txFifoIrqLevel;
		cfgRead[FLD_WAIT_LSB  +: 4] = cfg_reg.interframeWaitCount;
		cfgRead[FLD_ORDER_LSB +: 2] = cfg_reg.order;
		cfgRead[FLD_RXDLY]          = cfg_reg.rxDelay;
		cfgRead[FLD_RSVD_A]         = 1'b0;
		cfgRead[FLD_RSVD_B]         = 1'b0;
		stsRead = 32'h0000_0000;
		stsRead[STS_COUNT_LSB +: CW] = count_reg;
		stsRead[STS_FULL]            = (count_reg == CW'(TX_DEPTH));
		stsRead[STS_RXVALID]         = rxValid_reg;
		stsRead[STS_BUSY]            = (state_reg != ST_IDLE);
		stsRead[STS_TXREQ]           = txReq_reg;
	end

	// Register port, FIFO bookkeeping and interrupts
	always_comb begin
		cfg_next     = cfg_reg;
		irqMask_next = irqMask_reg;
		rdata_next   = 32'h0000_0000;
		push         = regWr && regAddr == OFF_DATA && count_reg != CW'(TX_DEPTH);
		if (regWr) begin
			case (regAddr)
				OFF_CONFIG: begin
					cfg_next.sizeM1              = regWdata[FLD_SIZE_LSB +: 5];
					cfg_next.txFifoIrqLevel      = regWdata[FLD_TXLVL_LSB +: 3];
					cfg_next.interframeWaitCount = regWdata[FLD_WAIT_LSB +: 4];
					cfg_next.order               = regWdata[FLD_ORDER_LSB +: 2];
					cfg_next.rxDelay             = regWdata[FLD_RXDLY];
				end
				OFF_IRQ_MASK: irqMask_next = regWdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (regRd) begin
			case (regAddr)
				OFF_CONFIG:   rdata_next = cfgRead;
				OFF_DATA:     rdata_next = rxHold_reg;
				OFF_STATUS:   rdata_next = stsRead;
				OFF_IRQ_STAT: rdata_next = {{(32-IRQ_W){1'b0}}, irqStat_reg};
				OFF_IRQ_MASK: rdata_next = {{(32-IRQ_W){1'b0}}, irqMask_reg};
				default:      rdata_next = 32'h0000_0000;
			endcase
		end
		wrPtr_next = push ? wrPtr_reg + PW'(1) : wrPtr_reg;
		rdPtr_next = pop ? rdPtr_reg + PW'(1) : rdPtr_reg;
		count_next = count_reg + CW'(push) - CW'(pop);
		txReq_next = count_next >= level;
		// Hardware set wins over a same-cycle clear
		irqStat_next = irqStat_reg;
		if (regWr && regAddr == OFF_IRQ_STAT) begin
			irqStat_next = irqStat_reg & ~regWdata[IRQ_W-1:0];
		end
		irqStat_next = irqStat_next | events;
		irq_next     = |(irqStat_next & irqMask_next);
	end

	// Link engine, mode 0 slave: sample on rising edge, shift on falling
	always_comb begin
		state_next   = state_reg;
		txWord_next  = txWord_reg;
		rxShift_next = rxShift_reg;
		rxHold_next  = rxHold_reg;
		rxValid_next = rxValid_reg;
		bitCnt_next  = bitCnt_reg;
		waitCnt_next = waitCnt_reg;
		miso_next    = miso_reg;
		misoOe_next  = selected;
		pop          = 1'b0;
		events[IRQ_FRAME] = 1'b0;
		events[IRQ_RXOVR] = 1'b0;
		events[IRQ_TXUND] = 1'b0;
		events[IRQ_TXREQ] = txReq_next & ~txReq_reg;
		if (regRd && regAddr == OFF_DATA) begin
			rxValid_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				miso_next = 1'b0;
				if (selected) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// An empty FIFO sends zeros rather than stalling the master
				if (count_reg != '0) begin
					pop         = 1'b1;
					txWord_next = popWord;
				end else begin
					txWord_next = 32'h0000_0000;
					events[IRQ_TXUND] = 1'b1;
				end
				bitCnt_next  = 5'h00;
				rxShift_next = 32'h0000_0000;
				miso_next    = txWord_next[bitIndex(5'h00, nBits, cfg_reg.order)];
				state_next   = ST_SHIFT;
			end
			ST_SHIFT: begin
				if (sclkRise) begin
					rxShift_next[bitIndex(bitCnt_reg, nBits, cfg_reg.order)] = rxBit;
					bitCnt_next = bitCnt_reg + 5'h01;
					if (bitCnt_reg == cfg_reg.sizeM1) begin
						rxHold_next  = rxShift_next;
						rxValid_next = 1'b1;
						events[IRQ_FRAME] = 1'b1;
						events[IRQ_RXOVR] = rxValid_reg & ~(regRd && regAddr == OFF_DATA);
						waitCnt_next = 4'h0;
						state_next   = (cfg_reg.interframeWaitCount != 4'h0) ? ST_WAIT : ST_LOAD;
					end
				end else if (sclkFall && bitCnt_reg != 5'h00) begin
					// The fall closing a frame or wait period carries no new bit
					miso_next = txWord_reg[bitIndex(bitCnt_reg, nBits, cfg_reg.order)];
				end
			end
			ST_WAIT: begin
				// Whole link clocks are skipped as wait states
				if (sclkRise) begin
					waitCnt_next = waitCnt_reg + 4'h1;
					if (waitCnt_next == cfg_reg.interframeWaitCount) begin
						state_next = ST_LOAD;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (!selected) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			fifoMem[wrPtr_reg] <= regWdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_reg     <= CFG_RESET;
			irqStat_reg <= '0;
			irqMask_reg <= '0;
			rdata_reg   <= 32'h0000_0000;
			irq_reg     <= 1'b0;
			txReq_reg   <= 1'b0;
			wrPtr_reg   <= '0;
			rdPtr_reg   <= '0;
			count_reg   <= '0;
			state_reg   <= ST_IDLE;
			txWord_reg  <= 32'h0000_0000;
			rxShift_reg <= 32'h0000_0000;
			rxHold_reg  <= 32'h0000_0000;
			rxValid_reg <= 1'b0;
			bitCnt_reg  <= 5'h00;
			waitCnt_reg <= 4'h0;
			miso_reg    <= 1'b0;
			misoOe_reg  <= 1'b0;
		end else begin
			cfg_reg     <= cfg_next;
			irqStat_reg <= irqStat_next;
			irqMask_reg <= irqMask_next;
			rdata_reg   <= rdata_next;
			irq_reg     <= irq_next;
			txReq_reg   <= txReq_next;
			wrPtr_reg   <= wrPtr_next;
			rdPtr_reg   <= rdPtr_next;
			count_reg   <= count_next;
			state_reg   <= state_next;
			txWord_reg  <= txWord_next;
			rxShift_reg <= rxShift_next;
			rxHold_reg  <= rxHold_next;
			rxValid_reg <= rxValid_next;
			bitCnt_reg  <= bitCnt_next;
			waitCnt_reg <= waitCnt_next;
			miso_reg    <= miso_next;
			misoOe_reg  <= misoOe_next;
		end
	end

	assign regRdata  = rdata_reg;
	assign spiMiso   = miso_reg;
	assign spiMisoOe = misoOe_reg;
	assign txReq     = txReq_reg;
	assign irq       = irq_reg;

endmodule
`default_nettype wire

/* File: sim/sff_spi_host.sv */
// External serial master model driving select, link clock and data
`timescale 1ns/1ps
`default_nettype none
module sff_spi_host (
	// Control
	input  wire logic        go,
	input  wire logic [5:0]  nBits,
	input  wire logic [1:0]  nFrames,
	input  wire logic [3:0]  waitPer,
	input  wire logic [31:0] txWord,
	// Link
	output var  logic        spiSclk,
	output var  logic        spiCsN,
	output var  logic        spiMosi,
	input  wire logic        spiMiso,
	// Result
	output var  logic [31:0] rxWord,
	output var  logic        done
);
	initial begin
		spiSclk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
		rxWord = '0;
		done = 1'b0;
		forever begin
			@(posedge go);
			#7 spiCsN = 1'b0;
			#160;
			for (int f = 0; f < nFrames; f++) begin
				rxWord = '0;
				for (int i = 0; i < nBits; i++) begin
					spiMosi = txWord[nBits - 1 - i];
					#160 spiSclk = 1'b1;
					rxWord = {rxWord[30:0], spiMiso};
					#160 spiSclk = 1'b0;
				end
				done = 1'b1;
				#1 done = 1'b0;
				// Idle clock periods between frames
				if (f < nFrames - 1) repeat (waitPer) begin
					#160 spiSclk = 1'b1;
					#160 spiSclk = 1'b0;
				end
			end
			// Released data line must not keep its last level
			spiCsN = 1'b1;
			spiMosi = ~spiMosi;
		end
	end
endmodule
`default_nettype wire

/* File: sim/sff_frame_ctrl_assertions.sv */
// Checker for configuration readback and request level
`timescale 1ns/1ps
`default_nettype none
module sff_frame_ctrl_chk import sff_pkg::*; #(
	parameter int TX_DEPTH = 16
) (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        spiSclk,
	input wire logic        spiCsN,
	input wire logic        spiMosi,
	input wire logic        spiMiso,
	input wire logic        spiMisoOe,
	input wire logic        txReq,
	input wire logic        irq
);
	logic [31:0] cfgSh;
	always_ff @(posedge core_clk) begin
		if (reset) cfgSh <= '0;
		else if (regWr && regAddr == OFF_CONFIG) cfgSh <= regWdata;
	end
	// Reserved codes behave as the lowest level
	function automatic logic [4:0] thr(input logic [2:0] c);
		return (c == TXLVL_4) ? 5'(LEVEL_4) : (c == TXLVL_8) ? 5'(LEVEL_8) : 5'(LEVEL_ONE);
	endfunction
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	rsvd_zero_a: assert property (regRd && regAddr == OFF_CONFIG |=>
		!regRdata[13] && !regRdata[20]) else $error("reserved bit reads one");
	lvl_back_a: assert property (regRd && regAddr == OFF_CONFIG |=>
		regRdata[12:10] == $past(cfgSh[12:10])) else $error("level readback wrong");
	wait_back_a: assert property (regRd && regAddr == OFF_CONFIG |=>
		regRdata[17:14] == $past(cfgSh[17:14])) else $error("wait readback wrong");
	order_back_a: assert property (regRd && regAddr == OFF_CONFIG |=>
		regRdata[19:18] == $past(cfgSh[19:18])) else $error("order readback wrong");
	delay_back_a: assert property (regRd && regAddr == OFF_CONFIG |=>
		regRdata[21] == $past(cfgSh[21])) else $error("delay readback wrong");
	txreq_level_a: assert property (regRd && regAddr == OFF_STATUS |=>
		regRdata[11] == (regRdata[4:0] >= thr($past(cfgSh[12:10]))))
		else $error("request level wrong");
	// Enable trails the select pin by two sync stages and one register
	miso_enable_a: assert property (spiMisoOe == !$past(spiCsN, 3))
		else $error("data output enable wrong");
endmodule
bind sff_frame_ctrl sff_frame_ctrl_chk #(.TX_DEPTH(TX_DEPTH)) chk_u (.core_clk(core_clk),
	.reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
	.spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .txReq(txReq), .irq(irq));
`default_nettype wire

/* File: sim/sff_frame_ctrl_tb_top.sv */
// Self-checking bench for the frame-format controller
`timescale 1ns/1ps
`default_nettype none
module sff_frame_ctrl_tb_top;
	import sff_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdata, rxWord, el, tw;
	logic        spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe, txReq, irq, done;
	logic        go = 1'b0;
	logic [5:0]  nBits = 6'h08;
	logic [1:0]  nFrames = 2'h1;
	logic [3:0]  waitPer = 4'h0;
	logic [31:0] txWord = 32'h0;
	logic        rdSeen = 1'b0;
	logic [31:0] seed = 32'h718221E9;
	logic [31:0] expQ[$], mskQ[$], linkQ[$];
	int          th[3] = '{LEVEL_ONE, LEVEL_4, LEVEL_8};
	int          n_errors = 0;
	int          n_tests = 0;
	always #20 core_clk = ~core_clk;
	sff_frame_ctrl dut_u (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.spiMisoOe(spiMisoOe), .txReq(txReq), .irq(irq));
	sff_spi_host host_u (.go(go), .nBits(nBits), .nFrames(nFrames), .waitPer(waitPer),
		.txWord(txWord), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMiso(spiMiso), .rxWord(rxWord), .done(done));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] cfgW(input logic [4:0] s, input logic [2:0] l,
			input logic [3:0] w, input logic [1:0] o, input logic d);
		return {10'h0, d, 1'b0, o, w, 1'b0, l, 5'h0, s};
	endfunction
	// Wire word holds the first sent bit at bit n-1
	function automatic logic [31:0] remap(input logic [1:0] o, input int n,
			input logic [31:0] w, input logic toEl);
		logic [31:0] r;
		int          idx;
		r = '0;
		for (int k = 0; k < n; k++) begin
			case (o)
				2'h0: idx = n - 1 - k;
				2'h1: idx = 8 * (k / 8) + 7 - k % 8;
				2'h2: idx = n - 8 - 8 * (k / 8) + k % 8;
				default: idx = k;
			endcase
			if (toEl) r[idx] = w[n - 1 - k];
			else r[n - 1 - k] = w[idx];
		end
		return r;
	endfunction
	task automatic fail(input logic [31:0] g, input logic [31:0] e);
		n_errors++;
		$display("[ERR] %0t got %h expected %h", $time, g, e);
	endtask
	task automatic cmpReg(input logic [31:0] e, input logic [31:0] m);
		n_tests++;
		if ((regRdata & m) !== (e & m)) fail(regRdata, e);
	endtask
	task automatic cmpLink(input logic [31:0] e);
		n_tests++;
		if (rxWord !== e) fail(rxWord, e);
	endtask
	task automatic cmpBit(input logic g, input logic e);
		n_tests++;
		if (g !== e) fail({31'h0, g}, {31'h0, e});
	endtask
	always @(posedge core_clk) begin
		rdSeen <= regRd;
		if (rdSeen) cmpReg(expQ.pop_front(), mskQ.pop_front());
	end
	always @(posedge done) cmpLink(linkQ.pop_front());
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask
	task automatic rst();
		reset <= 1'b1;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
	endtask
	task automatic frame(input int nb, input int nf, input int wt, input logic [31:0] w);
		@(posedge core_clk);
		nBits <= 6'(nb);
		nFrames <= 2'(nf);
		waitPer <= 4'(wt);
		txWord <= w;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (int k = 0; k < 4000 && linkQ.size() > 0; k++) @(posedge core_clk);
		if (linkQ.size() != 0) fail(32'(linkQ.size()), 32'h0);
		repeat (8) @(posedge core_clk);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#3000000;
		n_errors++;
		test_done();
	end
	initial begin
		rst();
		rd(OFF_CONFIG, 32'h00000007, '1);
		rd(8'h14, 32'h00000000, '1);
		repeat (4) begin
			el = rnd();
			wr(OFF_CONFIG, el);
			rd(OFF_CONFIG, el & 32'h002FDC1F, '1);
		end
		$display("test done: config fields");
		for (int lv = 0; lv < 3; lv++) begin
			rst();
			wr(OFF_CONFIG, cfgW(5'h07, 3'(lv), 4'h0, 2'h0, 1'b0));
			for (int n = 1; n < 10; n++) begin
				wr(OFF_DATA, rnd());
				rd(OFF_STATUS, {20'h0, n >= th[lv], 6'h0, 5'(n)}, 32'h0000081F);
				cmpBit(txReq, n >= th[lv]);
			end
		end
		$display("test done: request levels");
		rst();
		wr(OFF_IRQ_MASK, 32'h00000001);
		for (int o = 0; o < 4; o++) begin
			el = rnd() & 32'h0000FFFF;
			tw = rnd() & 32'h0000FFFF;
			wr(OFF_CONFIG, cfgW(5'h0F, 3'h0, 4'h0, 2'(o), o[0]));
			wr(OFF_DATA, el);
			linkQ.push_back(remap(2'(o), 16, el, 1'b0));
			frame(16, 1, 0, tw);
			rd(OFF_DATA, remap(2'(o), 16, tw, 1'b1), 32'h0000FFFF);
		end
		cmpBit(irq, 1'b1);
		wr(OFF_IRQ_STAT, 32'h0000000F);
		rd(OFF_IRQ_STAT, 32'h00000000, 32'h00000001);
		cmpBit(irq, 1'b0);
		$display("test done: element orders");
		wr(OFF_CONFIG, cfgW(5'h07, 3'h0, 4'h2, 2'h0, 1'b0));
		el = rnd() & 32'h000000FF;
		tw = rnd() & 32'h000000FF;
		wr(OFF_DATA, el);
		wr(OFF_DATA, el ^ 32'h000000FF);
		linkQ.push_back(el);
		linkQ.push_back(el ^ 32'h000000FF);
		frame(8, 2, 2, tw);
		rd(OFF_DATA, tw, 32'h000000FF);
		$display("test done: wait states");
		repeat (4) @(posedge core_clk);
		test_done();
	end
endmodule
`default_nettype wire
